// ==== logic/dejit_pkg.sv ====
// Purpose: shared constants and carriers for the rtp voice dejitter channel
// Assumes: 100 MHz core clock, classic wishbone register access
// Notes: register offsets are byte addresses of aligned 32-bit words
package dejit_pkg;

  // ***********************************************
  // register map
  // ***********************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LIMIT_OFS = 8'h04;
  localparam logic [7:0] PTR_OFS = 8'h08;
  localparam logic [7:0] BASE_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] DELTA_OFS = 8'h14;
  localparam logic [7:0] COUNT_OFS = 8'h18;
  localparam logic [7:0] LAST_OFS = 8'h1c;

  // control register bit positions
  localparam int RCA_BIT = 0;
  localparam int RCB_BIT = 1;
  localparam int AR_BIT = 2;
  localparam int SLIP_BIT = 3;
  localparam int LC_BIT = 4;
  localparam int LONG_BIT = 5;
  localparam int LOSS_BIT = 6;
  localparam int CNM_BIT = 7;
  localparam int BSZ_LSB = 8;
  localparam int RSTM_BIT = 11;
  localparam int INIT_BIT = 12;
  localparam int NCH_LSB = 16;

  localparam logic [2:0] BSZ_MAX = 3'h4;
  localparam int PTR_UNIT_SH = 5;
  localparam int BASE_UNIT_SH = 8;
  localparam int BUF_MIN_SH = 8;
  localparam logic [31:0] CTRL_RST = 32'h0001_0000;

  // one packet header as handed over by the disassembly path
  typedef struct packed {
    logic [15:0] seq;
    logic [31:0] ts;
    logic [31:0] local_ts;
    logic [11:0] samples;
    logic [11:0] bytes;
    logic comfort;
  } pkt_t;

  // clock recovery event
  typedef struct packed {
    logic [15:0] seq;
    logic [31:0] ts;
  } rec_t;

  // event report
  typedef struct packed {
    logic every;
    logic underrun;
    logic overrun;
    logic long_pkt;
    logic loss;
    logic first;
    logic [15:0] seq;
  } rpt_t;

endpackage : dejit_pkg

// ==== logic/dejit_channel.sv ====
// Purpose: per-channel receive handler placing rtp voice samples in a circular dejitter buffer
// Assumes: one packet header per cycle on a valid/ready handshake, wishbone classic slave
// Notes: the tdm readout side supplies its current read position as rd_pos_i
//
// How it works
// - pdv structure pointer is scaled by 32 bytes into fetch address
// - flag A set: every packet emits seq/timestamp event to recovery queue A
// - flag B set: same event to recovery queue B, independent of A
// - report-every-packet flag makes each packet generate an event report
// - slip flag reports buffer underrun or overrun
// - loss compensation places samples by rtp timestamp
// - without loss compensation samples follow previous packet, timestamp ignored
// - long packet flag reports packets exceeding the max expected samples
// - loss flag with compensation reports packets not placed back to back
// - comfort noise monitoring clear: comfort noise leaves delta fields untouched
// - monitoring set: comfort noise counted as last packet's sample count
// - size code 0..4 selects 256..4096 bytes, others reserved
// - comfort noise longer than configured maximum is truncated
// - channel count 1..255 sets interleave stride
// - restart bit set by software, cleared by hardware at next packet
// - new monitoring period loads min and max delta from first packet unless it is comfort noise with monitoring clear, which loads nothing
// - initialized bit set on the first received packet
// - buffer base address scaled by 256 bytes
// - a generated report carries every error seen on that packet
module dejit_channel
  import dejit_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pkt_valid_i,
  input wire dejit_pkg::pkt_t pkt_i,
  output logic pkt_ready_o,
  input wire logic [11:0] rd_pos_i,
  output logic [31:0] wr_addr_o,
  output logic [11:0] wr_len_o,
  output logic wr_valid_o,
  output logic [31:0] pdv_addr_o,
  output dejit_pkg::rec_t rec_a_o,
  output logic rec_a_valid_o,
  output dejit_pkg::rec_t rec_b_o,
  output logic rec_b_valid_o,
  output dejit_pkg::rpt_t rpt_o,
  output logic rpt_valid_o
);
  import dejit_pkg::*;

  // ***********************************************
  // registers
  // ***********************************************
  logic [31:0] ctrl_r;
  logic [31:0] limit_r;
  logic [31:0] ptr_r;
  logic [31:0] base_r;
  logic [31:0] delta_min_r;
  logic [31:0] delta_max_r;
  logic [31:0] pkt_cnt_r;
  logic [31:0] last_ts_r;
  logic [11:0] last_samples_r;
  logic [11:0] wr_pos_r;
  logic [31:0] stat_r;
  logic ack_r;

  // limit register: [11:0] max expected samples, [23:12] max comfort noise bytes
  wire logic [11:0] max_samples = limit_r[11:0];
  wire logic [11:0] max_cn = limit_r[23:12];
  wire logic [2:0] bsz = ctrl_r[BSZ_LSB+:3];
  wire logic [7:0] nch = ctrl_r[NCH_LSB+:8];

  // buffer size in bytes minus one, used as wrap mask
  function automatic logic [11:0] size_mask(input logic [2:0] code);
    logic [12:0] sz;
    sz = 13'h0001 << (BUF_MIN_SH + ((code > BSZ_MAX) ? 3'h0 : code));
    return 12'(sz - 13'h0001);
  endfunction : size_mask

  wire logic [11:0] mask = size_mask(bsz);

  // ***********************************************
  // wishbone slave
  // ***********************************************
  wire logic wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  wire logic wb_wr = wb_req && wb_we_i;
  wire logic [7:0] ofs = 8'(wb_adr_i);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8+:8] = nw[i*8+:8];
      end
    end
    return res;
  endfunction : merge

  // a restart asked for in the same cycle as a packet stays pending for the next packet
  wire logic [31:0] ctrl_wdat = merge(ctrl_r, wb_dat_i, wb_sel_i);
  wire logic rstm_req = wb_wr && (ofs == CTRL_OFS) && ctrl_wdat[RSTM_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
    end
  end
  assign wb_ack_o = ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_req) begin
      unique case (ofs)
        CTRL_OFS: wb_dat_o <= ctrl_r;
        LIMIT_OFS: wb_dat_o <= limit_r;
        PTR_OFS: wb_dat_o <= ptr_r;
        BASE_OFS: wb_dat_o <= base_r;
        STAT_OFS: wb_dat_o <= stat_r;
        DELTA_OFS: wb_dat_o <= {delta_max_r[15:0], delta_min_r[15:0]};
        COUNT_OFS: wb_dat_o <= pkt_cnt_r;
        LAST_OFS: wb_dat_o <= last_ts_r;
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ***********************************************
  // packet processing
  // ***********************************************
  wire logic take = pkt_valid_i && pkt_ready_o;
  assign pkt_ready_o = 1'b1;

  wire logic first_pkt = !ctrl_r[INIT_BIT];
  wire logic restart = ctrl_r[RSTM_BIT] || first_pkt;
  // comfort noise truncated to the configured length
  wire logic [11:0] cn_len = (pkt_i.bytes > max_cn) ? max_cn : pkt_i.bytes;
  wire logic [11:0] nsamp = pkt_i.comfort ? cn_len : pkt_i.samples;
  // byte offset of a sample index when nch channels are interleaved
  wire logic [11:0] stride = 12'(nch == 8'h00 ? 8'h01 : nch);
  wire logic [31:0] ts_gap = pkt_i.ts - last_ts_r;
  wire logic [11:0] seq_pos = wr_pos_r + 12'(last_samples_r * stride);
  wire logic [11:0] ts_pos = wr_pos_r + 12'(ts_gap[11:0] * stride);
  wire logic [11:0] target = (ctrl_r[LC_BIT] && !first_pkt) ? ts_pos & mask : seq_pos & mask;
  wire logic [11:0] span = 12'(nsamp * stride);
  wire logic [11:0] lead = (target - rd_pos_i) & mask;
  // back half of the ring counts as behind the read slot, front half as ahead of it
  wire logic [12:0] reach = {1'b0, lead} + {1'b0, span};
  wire logic [12:0] room = {1'b0, mask} + 13'h0001;
  wire logic underrun = !first_pkt && (lead > (mask >> 1));
  wire logic overrun = !first_pkt && !underrun && (reach > room);
  wire logic long_pkt = (max_samples != 12'h0) && (pkt_i.samples > max_samples);
  wire logic lost = ctrl_r[LC_BIT] && !first_pkt && (target != (seq_pos & mask));
  wire logic [31:0] delta = pkt_i.local_ts - pkt_i.ts;
  wire logic mon_upd = !pkt_i.comfort || ctrl_r[CNM_BIT];

  wire logic want_rpt = ctrl_r[AR_BIT] || (ctrl_r[SLIP_BIT] && (underrun || overrun))
    || (ctrl_r[LONG_BIT] && long_pkt)
    || (ctrl_r[LOSS_BIT] && ctrl_r[LC_BIT] && lost);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else begin
      if (wb_wr && ofs == CTRL_OFS) begin
        ctrl_r <= ctrl_wdat;
      end
      // the init set beats a software write; a fresh restart request beats the clear
      if (take) begin
        if (!rstm_req) begin
          ctrl_r[RSTM_BIT] <= 1'b0;
        end
        ctrl_r[INIT_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      limit_r <= 32'h0;
      ptr_r <= 32'h0;
      base_r <= 32'h0;
    end else if (wb_wr) begin
      if (ofs == LIMIT_OFS) begin
        limit_r <= merge(limit_r, wb_dat_i, wb_sel_i);
      end
      if (ofs == PTR_OFS) begin
        ptr_r <= merge(ptr_r, wb_dat_i, wb_sel_i);
      end
      if (ofs == BASE_OFS) begin
        base_r <= merge(base_r, wb_dat_i, wb_sel_i);
      end
    end
  end

  assign pdv_addr_o = ptr_r << PTR_UNIT_SH;

  // monitoring: comfort noise reuses last sample count, so position state is the same
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delta_min_r <= 32'h0;
      delta_max_r <= 32'h0;
    end else if (take && mon_upd) begin
      if (restart) begin
        delta_min_r <= delta;
        delta_max_r <= delta;
      end else begin
        if ($signed(delta) < $signed(delta_min_r)) begin
          delta_min_r <= delta;
        end
        if ($signed(delta) > $signed(delta_max_r)) begin
          delta_max_r <= delta;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pkt_cnt_r <= 32'h0;
      last_ts_r <= 32'h0;
      last_samples_r <= 12'h0;
      wr_pos_r <= 12'h0;
      stat_r <= 32'h0;
    end else if (take) begin
      pkt_cnt_r <= pkt_cnt_r + 32'h1;
      last_ts_r <= pkt_i.ts;
      // comfort noise spans as many frames as the last voice packet
      if (!pkt_i.comfort) begin
        last_samples_r <= pkt_i.samples;
      end
      wr_pos_r <= target;
      stat_r <= {26'h0, first_pkt, lost, long_pkt, overrun, underrun, want_rpt};
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_addr_o <= 32'h0;
      wr_len_o <= 12'h0;
      wr_valid_o <= 1'b0;
      rec_a_o <= '0;
      rec_b_o <= '0;
      rec_a_valid_o <= 1'b0;
      rec_b_valid_o <= 1'b0;
      rpt_o <= '0;
      rpt_valid_o <= 1'b0;
    end else begin
      wr_valid_o <= take;
      rec_a_valid_o <= take && ctrl_r[RCA_BIT];
      rec_b_valid_o <= take && ctrl_r[RCB_BIT];
      rpt_valid_o <= take && want_rpt;
      if (take) begin
        wr_addr_o <= (base_r << BASE_UNIT_SH) + {20'h0, target};
        wr_len_o <= span;
        rec_a_o <= '{seq: pkt_i.seq, ts: pkt_i.ts};
        rec_b_o <= '{seq: pkt_i.seq, ts: pkt_i.ts};
        // every detected error rides along once a report is produced
        rpt_o <= '{every: ctrl_r[AR_BIT], underrun: underrun, overrun: overrun,
          long_pkt: long_pkt, loss: lost, first: first_pkt, seq: pkt_i.seq};
      end
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  a_rec_a_event: assert property (@(posedge clk_i) disable iff (rst_i)
    take && ctrl_r[RCA_BIT] |=> rec_a_valid_o && rec_a_o.seq == $past(pkt_i.seq))
    else $error("queue A event missing");
  a_rec_b_event: assert property (@(posedge clk_i) disable iff (rst_i)
    take && ctrl_r[RCB_BIT] |=> rec_b_valid_o && rec_b_o.ts == $past(pkt_i.ts))
    else $error("queue B event missing");
  a_every_report: assert property (@(posedge clk_i) disable iff (rst_i)
    take && ctrl_r[AR_BIT] |=> rpt_valid_o && rpt_o.every)
    else $error("report every packet missing");
  a_slip_report: assert property (@(posedge clk_i) disable iff (rst_i)
    take && ctrl_r[SLIP_BIT] && (underrun || overrun) |=> rpt_valid_o)
    else $error("slip not reported");
  a_long_report: assert property (@(posedge clk_i) disable iff (rst_i)
    take && ctrl_r[LONG_BIT] && long_pkt |=> rpt_valid_o && rpt_o.long_pkt)
    else $error("long packet not reported");
  a_restart_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    take && !rstm_req |=> !ctrl_r[RSTM_BIT])
    else $error("restart bit not cleared");
  a_restart_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    take && rstm_req |=> ctrl_r[RSTM_BIT])
    else $error("fresh restart request lost");
  a_init_set: assert property (@(posedge clk_i) disable iff (rst_i)
    take |=> ctrl_r[INIT_BIT])
    else $error("initialized bit not set");
  a_restart_load: assert property (@(posedge clk_i) disable iff (rst_i)
    take && restart && mon_upd |=> delta_min_r == $past(delta) && delta_max_r == $past(delta))
    else $error("monitoring period not restarted");
  a_cn_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    take && pkt_i.comfort && !ctrl_r[CNM_BIT] |=> $stable(delta_min_r) && $stable(delta_max_r))
    else $error("comfort noise touched monitoring");
  a_back_to_back: assert property (@(posedge clk_i) disable iff (rst_i)
    take && !ctrl_r[LC_BIT] |=> wr_pos_r == (($past(wr_pos_r) + 12'($past(last_samples_r) * $past(stride))) & $past(mask)))
    else $error("back to back placement wrong");
  // placement is recomputed from the packet timestamps themselves, with one channel
  a_ts_place: assert property (@(posedge clk_i) disable iff (rst_i)
    take && ctrl_r[LC_BIT] && !first_pkt && nch == 8'h01 |=> wr_pos_r == (12'($past(wr_pos_r) + $past(pkt_i.ts) - $past(last_ts_r)) & $past(mask)))
    else $error("timestamp placement wrong");
  a_loss_report: assert property (@(posedge clk_i) disable iff (rst_i)
    take && ctrl_r[LOSS_BIT] && ctrl_r[LC_BIT] && lost |=> rpt_valid_o && rpt_o.loss)
    else $error("packet loss not reported");
  a_loss_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    take && ctrl_r[LC_BIT] && !first_pkt && nch == 8'h01 && (pkt_i.ts - last_ts_r == 32'(last_samples_r)) |=> !rpt_o.loss)
    else $error("contiguous packet flagged as loss");
  a_cn_truncate: assert property (@(posedge clk_i) disable iff (rst_i)
    take && pkt_i.comfort && (pkt_i.bytes > max_cn) && nch == 8'h01 |=> wr_len_o == $past(max_cn))
    else $error("comfort noise not truncated");
  a_first_no_slip: assert property (@(posedge clk_i) disable iff (rst_i)
    take && first_pkt |=> !rpt_o.underrun && !rpt_o.overrun)
    else $error("first packet flagged as slip");
  a_stride_len: assert property (@(posedge clk_i) disable iff (rst_i)
    take && !pkt_i.comfort && nch != 8'h00 |=> wr_len_o == 12'($past(pkt_i.samples) * $past(nch)))
    else $error("interleaved length wrong");
  a_wr_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    take |=> wr_valid_o)
    else $error("buffer write missing");
  a_ptr_scale: assert property (@(posedge clk_i) disable iff (rst_i)
    pdv_addr_o[PTR_UNIT_SH-1:0] == '0 && pdv_addr_o[31:PTR_UNIT_SH] == ptr_r[31-PTR_UNIT_SH:0])
    else $error("monitoring pointer scaling wrong");
  a_rpt_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    rpt_valid_o |-> rpt_o.every || rpt_o.underrun || rpt_o.overrun || rpt_o.long_pkt || rpt_o.loss)
    else $error("report without a cause");
  a_rec_both: assert property (@(posedge clk_i) disable iff (rst_i)
    take && ctrl_r[RCA_BIT] && ctrl_r[RCB_BIT] |=> rec_a_valid_o && rec_b_valid_o)
    else $error("recovery queues not independent");

endmodule : dejit_channel

// ==== dv/pkt_src.sv ====
// Purpose: model of the upstream disassembly engine that hands over packet headers
// Assumes: ready is sampled at the rising edge that takes the header
// Notes: idle header lines show the inverse of the last header so stale data never looks valid
module pkt_src (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic valid_o,
  output dejit_pkg::pkt_t pkt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dejit_pkg::*;

  initial begin
    valid_o = 1'b0;
    pkt_o = '0;
  end

  task automatic send(input pkt_t p);
    @(posedge clk_i);
    valid_o <= 1'b1;
    pkt_o <= p;
    do @(posedge clk_i); while (ready_i !== 1'b1);
    valid_o <= 1'b0;
    pkt_o <= ~p;
  endtask : send
endmodule : pkt_src

// ==== dv/dejit_channel_tb.sv ====
// Purpose: self-checking bench for the rtp voice dejitter channel
// Assumes: wishbone classic master, packet headers from pkt_src
// Notes: rd_pos_i sits at the first write; besides the slip checks, slips (unreported) meet only the half-ring checks of the size-code loop
module dejit_channel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dejit_pkg::*;

  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pkt_valid_i, pkt_ready_o;
  logic wr_valid_o, rec_a_valid_o, rec_b_valid_o, rpt_valid_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, wr_addr_o, pdv_addr_o, q, o1, s;
  logic [11:0] rd_pos_i, wr_len_o;
  pkt_t pkt_i;
  rec_t rec_a_o, rec_b_o;
  rpt_t rpt_o;
  int n_errors, comparisons;

  dejit_channel u_dejit_channel (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .pkt_valid_i, .pkt_i, .pkt_ready_o, .rd_pos_i, .wr_addr_o, .wr_len_o,
    .wr_valid_o, .pdv_addr_o, .rec_a_o, .rec_a_valid_o, .rec_b_o, .rec_b_valid_o, .rpt_o, .rpt_valid_o);
  pkt_src u_pkt_src (.clk_i, .ready_i(pkt_ready_o), .valid_o(pkt_valid_i), .pkt_o(pkt_i));

  // ***********************************************
  // access tasks
  // ***********************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // seq follows the timestamp so events can be predicted from ts alone
  task automatic send(input logic [31:0] ts, input logic [31:0] dl, input logic [11:0] n,
                      input logic [11:0] by, input logic cn);
    pkt_t p;
    p = '{ts[15:0], ts, ts + dl, n, by, cn};
    u_pkt_src.send(p);
    #1;
  endtask : send

  task automatic print_verdict();
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // ***********************************************
  // stimulus
  // ***********************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    #50000;
    n_errors++;
    print_verdict();
  end

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    rd_pos_i = 12'h000;
    n_errors = 0;
    comparisons = 0;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, CTRL_OFS, 32'h0);
    check(q, 32'h0001_0000);
    wb(1, PTR_OFS, 32'h5);
    check(pdv_addr_o, 32'ha0);
    for (int i = 0; i < 4; i++) begin
      wb(1, CTRL_OFS, 32'h0001_0000 | i);
      send(32'h100 * i, 32'h0, 12'h8, 12'h8, 1'b0);
      check(rec_a_valid_o, i[0]);
      check(rec_b_valid_o, i[1]);
      if (i[0]) check(rec_a_o.ts, 32'h100 * i);
      if (i[1]) check(rec_b_o.seq, 32'h100 * i);
      wb(0, CTRL_OFS, 32'h0);
      check(q[12], 1'b1);
    end
    wb(1, LIMIT_OFS, 32'h8);
    wb(1, CTRL_OFS, 32'h0001_0004);
    send(32'h2000, 32'h0, 12'h9, 12'h9, 1'b0);
    check({rpt_valid_o, rpt_o.every, rpt_o.long_pkt}, 3'h7);
    check(rpt_o.seq, 32'h2000);
    wb(1, CTRL_OFS, 32'h0001_0020);
    send(32'h2000, 32'h0, 12'h8, 12'h8, 1'b0);
    send(32'h2008, 32'h0, 12'h8, 12'h8, 1'b0);
    check(rpt_valid_o, 1'b0);
    send(32'h2010, 32'h0, 12'h9, 12'h9, 1'b0);
    check({rpt_valid_o, rpt_o.every, rpt_o.long_pkt}, 3'h5);
    wb(1, BASE_OFS, 32'h3);
    // only the defined size codes are programmed
    for (int c = 0; c < 5; c++) begin
      s = 32'h100 << c;
      wb(1, CTRL_OFS, 32'h0001_0000 | (c << 8));
      send(32'h0, 32'h0, s[13:2], s[13:2], 1'b0);
      o1 = wr_addr_o - 32'h300;
      check(o1 < s, 1'b1);
      rd_pos_i <= o1[11:0];
      send(32'h7777, 32'h0, s[13:2], s[13:2], 1'b0);
      check(wr_addr_o, 32'h300 + ((o1 + s / 4) % s));
      send(32'h10, 32'h0, s[13:2], s[13:2], 1'b0);
      check(wr_addr_o, 32'h300 + ((o1 + s / 2) % s));
    end
    wb(1, CTRL_OFS, 32'h00ff_0000);
    send(32'h0, 32'h0, 12'h2, 12'h1fe, 1'b0);
    check(wr_len_o, 32'h1fe);
    wb(1, CTRL_OFS, 32'h0001_0050);
    send(32'h0, 32'h0, 12'h8, 12'h8, 1'b0);
    o1 = wr_addr_o - 32'h300;
    rd_pos_i <= o1[11:0];
    send(32'h8, 32'h0, 12'h8, 12'h8, 1'b0);
    check(rpt_valid_o, 1'b0);
    send(32'h14, 32'h0, 12'h8, 12'h8, 1'b0);
    check(wr_addr_o, 32'h300 + ((o1 + 32'h14) % 32'h100));
    check({rpt_valid_o, rpt_o.loss}, 2'h3);
    wb(1, LIMIT_OFS, 32'h4000);
    wb(1, CTRL_OFS, 32'h0001_0800);
    send(32'h1000, 32'h25, 12'h8, 12'h8, 1'b0);
    wb(0, CTRL_OFS, 32'h0);
    check(q[11], 1'b0);
    wb(0, DELTA_OFS, 32'h0);
    check(q, 32'h0025_0025);
    send(32'h1008, 32'h40, 12'h8, 12'ha, 1'b1);
    check(wr_len_o, 32'h4);
    wb(0, DELTA_OFS, 32'h0);
    check(q, 32'h0025_0025);
    wb(1, CTRL_OFS, 32'h0001_1080);
    send(32'h1010, 32'h30, 12'h8, 12'h8, 1'b0);
    send(32'h1018, 32'h50, 12'h8, 12'h1, 1'b1);
    wb(0, DELTA_OFS, 32'h0);
    check(q, 32'h0050_0025);
    // slips: read slot just ahead of the target, then a long packet that wraps onto it
    wb(1, CTRL_OFS, 32'h0001_0008);
    send(32'h0, 32'h0, 12'h8, 12'h8, 1'b0);
    check(wr_valid_o, 1'b1);
    o1 = wr_addr_o - 32'h300;
    rd_pos_i <= 12'(o1 + 32'h10);
    send(32'h8, 32'h0, 12'h8, 12'h8, 1'b0);
    check({rpt_valid_o, rpt_o.underrun, rpt_o.overrun}, 3'h6);
    rd_pos_i <= 12'(o1 - 32'h60);
    send(32'h10, 32'h0, 12'ha0, 12'ha0, 1'b0);
    check({rpt_valid_o, rpt_o.underrun, rpt_o.overrun}, 3'h5);
    wb(0, STAT_OFS, 32'h0);
    check(q, 32'h5);
    print_verdict();
  end
endmodule : dejit_channel_tb
